// *** hw/uart_tx_params.svh ***
// Purpose: Offsets, field positions and reset values of the transmitter.
// Assumes: 32-bit AXI4-Lite register words, 8-bit byte address.
// Notes:   Definitions only.
`ifndef UART_TX_PARAMS_SVH
`define UART_TX_PARAMS_SVH

// ==========================================================================
// Register offsets
`define ADDR_CTRL    8'h00
`define ADDR_DIVISOR 8'h04
`define ADDR_DATA    8'h08
`define ADDR_STATUS  8'h0c
`define ADDR_ISTAT   8'h10
`define ADDR_IMASK   8'h14

// ==========================================================================
// Field positions
`define CTRL_EN_BIT    0
`define CTRL_HS_BIT    1
`define CTRL_WIDE_BIT  2
`define CTRL_IE_BIT    3
`define EV_SENT_BIT    0
`define EV_FREE_BIT    1

// ==========================================================================
// Reset values and framing
`define DIVISOR_RESET  16'h0000
`define FRAME_LAST_BIT 4'h9
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// *** hw/uart_tx_pkg.sv ***
// Purpose: Types shared by the transmitter design.
// Assumes: Constants live in uart_tx_params.svh.
// Notes:   Types only.
package uart_tx_pkg;

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;

  typedef struct packed {
    logic        ie;
    logic        wide;
    logic        hs;
    logic        en;
  } ctrl_s;

  typedef struct packed {
    logic        load;
    logic [15:0] value;
  } autobaud_s;

  typedef struct packed {
    ctrl_s       ctrl;
    logic [15:0] div;
    logic [7:0]  hold;
    logic        hold_full;
    tx_state_e   state;
    logic [9:0]  shreg;
    logic [3:0]  bitcnt;
    logic [17:0] pre;
    logic        flag;
    logic [1:0]  ists;
    logic [1:0]  imask;
    logic        tx_line_low;
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } st_s;

endpackage

// *** hw/uart_tx.sv ***
// Purpose: Serial transmitter with holding buffer, empty flag and baud
//          generator, reached over AXI4-Lite.
// Assumes: aclk is the oscillator; autobaud inputs come from aclk logic.
// Notes:   One packed state struct, two always_comb, one always_ff.
//
// Notes on behaviour
// - The empty flag is high when enabled unless a char waits behind a shift.
// - The empty flag shows a buffer write from the second cycle after it.
// - Software cannot write the empty flag; it follows the enable and the buffer.
// - The interrupt enable gates the empty flag's request but not the flag itself or the masked ists requests.
// - Software or auto-baud may rewrite the divisor for later bits.
// - High-speed wide mode: divisor 832 at 32 MHz gives 9604 baud.
// - The empty flag rises once the transmitter is enabled.
// - A char written while shifting loads once the stop bit ends.
`include "uart_tx_params.svh"

module uart_tx (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire uart_tx_pkg::autobaud_s autobaud,
  output logic                        tx_out,
  output logic                        irq
);

  uart_tx_pkg::st_s s_r;
  uart_tx_pkg::st_s s_nxt;
  logic             do_wr;
  logic [17:0]      bit_limit;
  logic [1:0]       ev;
  logic [1:0]       w1c;
  logic             shifting;

  // ========================================================================
  // Bus handshakes
  assign s_axi_awready = ~s_r.aw_full;
  assign s_axi_wready  = ~s_r.w_full;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = ~s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = s_r.rdata;
  assign do_wr         = s_r.aw_full & s_r.w_full & ~s_r.bvalid;
  assign shifting      = (s_r.state == uart_tx_pkg::TX_SHIFT);
  assign tx_out        = ~s_r.tx_line_low;

  // ========================================================================
  // Baud timing
  // In the other modes a bit lasts sixteen clocks times the low byte plus one.
  always_comb begin
    if (s_r.ctrl.hs && s_r.ctrl.wide) begin
      bit_limit = {s_r.div, 2'h3};
    end else begin
      bit_limit = {6'h00, s_r.div[7:0], 4'hf};
    end
  end

  assign irq = (s_r.flag & s_r.ctrl.ie) | (|(s_r.ists & s_r.imask));

  // ========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    ev    = 2'h0;
    w1c   = 2'h0;

    if (s_axi_awvalid && !s_r.aw_full) begin
      s_nxt.aw_full = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_full) begin
      s_nxt.w_full = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Auto-baud updates first so that a software write in the same cycle
    // takes precedence.
    if (autobaud.load) begin
      s_nxt.div = autobaud.value;
    end

    if (do_wr) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = `RESP_OKAY;
      case (s_r.aw_addr)
        `ADDR_CTRL: begin
          if (s_r.w_strb[0]) begin
            s_nxt.ctrl = s_r.w_data[3:0];
          end
        end
        `ADDR_DIVISOR: begin
          if (s_r.w_strb[0]) begin
            s_nxt.div[7:0] = s_r.w_data[7:0];
          end
          if (s_r.w_strb[1]) begin
            s_nxt.div[15:8] = s_r.w_data[15:8];
          end
        end
        `ADDR_DATA: begin
          // A full buffer drops the new character.
          if (s_r.w_strb[0] && s_r.ctrl.en && !s_r.hold_full) begin
            s_nxt.hold      = s_r.w_data[7:0];
            s_nxt.hold_full = 1'b1;
          end
        end
        `ADDR_STATUS: begin
          // Status is read-only; writes are accepted and discarded.
        end
        `ADDR_ISTAT: begin
          if (s_r.w_strb[0]) begin
            w1c = s_r.w_data[1:0];
          end
        end
        `ADDR_IMASK: begin
          if (s_r.w_strb[0]) begin
            s_nxt.imask = s_r.w_data[1:0];
          end
        end
        default: begin
          s_nxt.bresp = `RESP_SLVERR;
        end
      endcase
    end

    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `RESP_OKAY;
      s_nxt.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        `ADDR_CTRL:    s_nxt.rdata[3:0]  = s_r.ctrl;
        `ADDR_DIVISOR: s_nxt.rdata[15:0] = s_r.div;
        `ADDR_DATA:    s_nxt.rdata[7:0]  = s_r.hold;
        `ADDR_STATUS:  s_nxt.rdata[2:0]  = {s_r.hold_full, shifting, s_r.flag};
        `ADDR_ISTAT:   s_nxt.rdata[1:0]  = s_r.ists;
        `ADDR_IMASK:   s_nxt.rdata[1:0]  = s_r.imask;
        default:       s_nxt.rresp       = `RESP_SLVERR;
      endcase
    end

    // Transmit engine.
    case (s_r.state)
      uart_tx_pkg::TX_IDLE: begin
        if (s_r.ctrl.en && s_r.hold_full) begin
          s_nxt.shreg     = {1'b1, s_r.hold, 1'b0};
          s_nxt.hold_full = 1'b0;
          s_nxt.state     = uart_tx_pkg::TX_SHIFT;
          s_nxt.pre       = 18'h00000;
          s_nxt.bitcnt    = 4'h0;
          ev[`EV_FREE_BIT] = 1'b1;
        end
      end
      uart_tx_pkg::TX_SHIFT: begin
        // A smaller divisor written mid-bit ends the bit at once instead
        // of letting the counter run round.
        if (s_r.pre >= bit_limit) begin
          s_nxt.pre    = 18'h00000;
          s_nxt.shreg  = {1'b1, s_r.shreg[9:1]};
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          if (s_r.bitcnt == `FRAME_LAST_BIT) begin
            s_nxt.state = uart_tx_pkg::TX_IDLE;
            ev[`EV_SENT_BIT] = 1'b1;
          end
        end else begin
          s_nxt.pre = s_r.pre + 18'h00001;
        end
      end
      default: begin
        s_nxt.state = uart_tx_pkg::TX_IDLE;
      end
    endcase

    if (!s_r.ctrl.en) begin
      s_nxt.state     = uart_tx_pkg::TX_IDLE;
      s_nxt.hold_full = 1'b0;
      ev              = 2'h0;
    end

    s_nxt.tx_line_low = (s_nxt.state == uart_tx_pkg::TX_SHIFT) &
                        ~s_nxt.shreg[0];
    // Set wins over a same-cycle clear.
    s_nxt.ists = (s_r.ists & ~w1c) | ev;
    // One register stage gives the required two-cycle lag.
    s_nxt.flag = s_r.ctrl.en & ~(s_r.hold_full & shifting);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence load_seq;
    !shifting && s_r.ctrl.en && s_r.hold_full;
  endsequence

  sequence start_seq;
    shifting && s_r.tx_line_low && s_r.bitcnt == 4'h0 && !s_r.hold_full;
  endsequence

  AST_FLAG_SET: assert property (
    (s_r.ctrl.en && !s_r.hold_full) |=> s_r.flag)
    else $error("Empty flag low with an empty buffer.");

  AST_FLAG_CLR: assert property (
    (s_r.ctrl.en && s_r.hold_full && shifting) |=> !s_r.flag)
    else $error("Empty flag high with a queued character.");

  AST_FLAG_LAG: assert property (
    (do_wr && s_r.aw_addr == `ADDR_DATA && shifting && s_r.flag &&
     s_r.pre < bit_limit) |=> s_r.flag)
    else $error("Empty flag changed in the cycle after a buffer write.");

  AST_FLAG_RO: assert property (
    (do_wr && s_r.aw_addr == `ADDR_STATUS && s_r.ctrl.en && !s_r.hold_full)
    |=> s_r.flag)
    else $error("A status write disturbed the empty flag.");

  AST_IRQ_GATE: assert property (
    (!s_r.ctrl.ie && (s_r.ists & s_r.imask) == 2'h0) |-> !irq)
    else $error("Interrupt raised while the enable is clear.");

  AST_EN_FLAG: assert property (
    ($rose(s_r.ctrl.en) && !s_r.hold_full) |=> s_r.flag)
    else $error("Empty flag did not rise after enable.");

  AST_BIT_WRAP: assert property (
    (shifting && s_r.ctrl.en && s_r.pre == bit_limit &&
     s_r.bitcnt != `FRAME_LAST_BIT) |=> (s_r.pre == 18'h00000 && shifting))
    else $error("Bit period counter did not wrap at the limit.");

  AST_LOAD_START: assert property (
    load_seq |=> start_seq)
    else $error("Queued character did not start with a start bit.");

  AST_HOLD_WAIT: assert property (
    (shifting && s_r.ctrl.en && s_r.hold_full &&
     !(s_r.pre >= bit_limit && s_r.bitcnt == `FRAME_LAST_BIT))
    |=> (s_r.hold_full && shifting))
    else $error("Queued character left the buffer before the stop bit.");

  AST_STOP_HIGH: assert property (
    (shifting && s_r.bitcnt == `FRAME_LAST_BIT) |-> !s_r.tx_line_low)
    else $error("Stop bit is not a mark.");

  AST_AUTOBAUD: assert property (
    (autobaud.load && !(do_wr && s_r.aw_addr == `ADDR_DIVISOR))
    |=> s_r.div == $past(autobaud.value))
    else $error("Auto-baud value not taken.");

endmodule

// *** verification/uart_rx_model.sv ***
// Purpose: Remote receiver model watching the serial line.
// Assumes: bit_clks gives the bit length in clocks; data bit 0 is one.
// Notes:   start_len counts the clocks of the start bit.
module uart_rx_model (
  input  wire logic        aclk,
  input  wire logic        line,
  input  wire logic [15:0] bit_clks,
  output logic [7:0]       rx_byte,
  output logic             stop_ok,
  output int               rx_count,
  output int               start_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] sh;
  initial begin
    rx_count = 0;
    forever begin
      @(posedge aclk iff !line);
      start_len = 0;
      while (!line) begin
        start_len++;
        @(posedge aclk);
      end
      for (int i = 0; i < 9; i++) begin
        repeat (bit_clks / 2) @(posedge aclk);
        sh[i] = line;
        if (i < 8) repeat (bit_clks - bit_clks / 2) @(posedge aclk);
      end
      rx_byte = sh[7:0];
      stop_ok = sh[8];
      rx_count++;
    end
  end
endmodule

// *** verification/uart_tx_flag_and_baud_gen_bench.sv ***
// Purpose: Self-checking bench of the serial transmitter.
// Assumes: Seed 57; the receiver model times bits on tx_out.
// Notes:   Bytes sent have bit 0 set so the start bit can be timed.
`include "uart_tx_params.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  err_total++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module uart_tx_flag_and_baud_gen_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   aclk, aresetn, tx_out, irq, stop_ok;
  logic [7:0]             s_axi_awaddr, s_axi_araddr, rx_byte;
  logic [31:0]            s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]             s_axi_wstrb;
  logic [1:0]             s_axi_bresp, s_axi_rresp, rs;
  logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                   s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                   s_axi_arvalid, s_axi_arready;
  logic                   s_axi_rvalid, s_axi_rready;
  uart_tx_pkg::autobaud_s autobaud;
  logic [15:0]            bit_clks, dv;
  logic [7:0]             ch [2];
  int                     rx_count, start_len;
  int                     err_total = 0;
  int                     total_checks = 0;
  int                     cyc = 0;

  uart_tx dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .autobaud, .tx_out, .irq);
  uart_rx_model rx (.aclk, .line(tx_out), .bit_clks, .rx_byte, .stop_ok,
    .rx_count, .start_len);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      end_sim();
    end
  end

  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk iff s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // ==========================================================
  // Tests
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    bit_clks = 16'h0004;
    rd = $urandom(57);
    autobaud = '{1'b0, 16'($urandom)};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(`ADDR_STATUS);
    `CHK(rd[0], 1'b0)
    rdr(8'h20);
    `CHK(rs, `RESP_SLVERR)
    wr(8'h20, 32'h0000_000f);
    `CHK(rs, `RESP_SLVERR)
    $display("test reset and bus done");
    dv = 16'($urandom_range(3, 0));
    wr(`ADDR_DIVISOR, {16'h0000, dv});
    bit_clks <= 16'(4 * (dv + 1));
    wr(`ADDR_CTRL, 32'h0000_0007);
    rdr(`ADDR_STATUS);
    `CHK(rd[0], 1'b1)
    wr(`ADDR_STATUS, 32'h0000_0000);
    rdr(`ADDR_STATUS);
    `CHK(rd[0], 1'b1)
    `CHK(irq, 1'b0)
    $display("test enable done");
    wr(`ADDR_CTRL, 32'h0000_000f);
    `CHK(irq, 1'b1)
    foreach (ch[i]) ch[i] = 8'($urandom) | 8'h01;
    wr(`ADDR_DATA, {24'h0, ch[0]});
    wr(`ADDR_DATA, {24'h0, ch[1]});
    wr(`ADDR_CTRL, 32'h0000_0007);
    rdr(`ADDR_STATUS);
    `CHK(rd[2:0], 3'h6)
    @(posedge aclk iff rx_count == 1);
    `CHK(rx_byte, ch[0])
    @(posedge aclk iff rx_count == 2);
    `CHK(rx_byte, ch[1])
    `CHK(stop_ok, 1'b1)
    `CHK(start_len, 4 * (dv + 1))
    rdr(`ADDR_STATUS);
    `CHK(rd[0], 1'b1)
    `CHK(irq, 1'b0)
    $display("test queue done");
    wr(`ADDR_IMASK, 32'h0000_0003);
    `CHK(irq, 1'b1)
    rdr(`ADDR_ISTAT);
    `CHK(rd[1:0], 2'h3)
    wr(`ADDR_ISTAT, 32'h0000_0001);
    rdr(`ADDR_ISTAT);
    `CHK(rd[1:0], 2'h2)
    wr(`ADDR_ISTAT, 32'h0000_0002);
    `CHK(irq, 1'b0)
    wr(`ADDR_IMASK, 32'h0000_0000);
    $display("test interrupts done");
    @(posedge aclk);
    autobaud <= '{1'b1, 16'd832};
    @(posedge aclk);
    autobaud.load <= 1'b0;
    bit_clks <= 16'd3332;
    rdr(`ADDR_DIVISOR);
    `CHK(rd[15:0], 16'd832)
    wr(`ADDR_DATA, {24'h0, ch[0]});
    @(posedge aclk iff rx_count == 3);
    `CHK(rx_byte, ch[0])
    `CHK(start_len, 3332)
    $display("test auto-baud done");
    wr(`ADDR_CTRL, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    rdr(`ADDR_STATUS);
    `CHK(rd[0], 1'b0)
    `CHK(tx_out, 1'b1)
    $display("test disable done");
    wr(`ADDR_DIVISOR, {16'h0000, dv});
    bit_clks <= 16'(16 * (dv + 1));
    wr(`ADDR_CTRL, 32'h0000_0001);
    wr(`ADDR_DATA, {24'h0, ch[1]});
    @(posedge aclk iff rx_count == 4);
    `CHK(rx_byte, ch[1])
    `CHK(stop_ok, 1'b1)
    `CHK(start_len, 16 * (dv + 1))
    $display("test low-speed mode done");
    end_sim();
  end
endmodule
